// ---- rtl/tpm_pkg.sv ----
// constants and types shared by the throttle pin monitor
package tpm_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_PERIOD = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_COUNT  = 5'h10;
  localparam logic [4:0] OFF_LIMIT  = 5'h14;

  // ---------------------------------------------------------------
  // status/control field positions
  // ---------------------------------------------------------------
  localparam int BIT_MON_ON   = 0;
  localparam int BIT_PIN_VIEW = 1;
  localparam int BIT_AIE      = 2;
  localparam int BIT_PIE      = 3;
  localparam int BIT_SRST     = 4;
  localparam int BIT_FILT_ON  = 5;
  localparam int BIT_AFLAG    = 10;
  localparam int BIT_PFLAG    = 11;

  // ---------------------------------------------------------------
  // widths, limits and timing
  // ---------------------------------------------------------------
  localparam int          CNT_W       = 16;
  localparam int          PER_W       = 24;
  localparam int          TICK_W      = 16;
  localparam int          FILT_DEPTH  = 3;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam int          CLK_PER_PS  = 5000;
  localparam int          TICK_PER_PS = 10000000;
  localparam int          TICK_CYC    = TICK_PER_PS / CLK_PER_PS;

  // ---------------------------------------------------------------
  // whole state of the monitor
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [TICK_W-1:0]     tick_cnt;
    logic [FILT_DEPTH-1:0] samp;
    logic                  filt;
    logic                  pin_view;
    logic [CNT_W-1:0]      acnt;
    logic [7:0]            hold;
    logic [PER_W-1:0]      pcnt;
    logic [PER_W-1:0]      period;
    logic [CNT_W-1:0]      limit;
    logic                  pflag;
    logic                  aflag;
    logic                  filt_on;
    logic                  pie;
    logic                  aie;
    logic                  mon_on;
  } tpm_state_t;

  localparam tpm_state_t RESET_ST = '{
    ack:      1'h0,
    rdata:    32'h0000_0000,
    tick_cnt: 16'h0000,
    samp:     3'h7,
    filt:     1'h1,
    pin_view: 1'h0,
    acnt:     16'h0000,
    hold:     8'h00,
    pcnt:     24'h00_0000,
    period:   24'h00_0000,
    limit:    16'h0000,
    pflag:    1'h0,
    aflag:    1'h0,
    filt_on:  1'h0,
    pie:      1'h0,
    aie:      1'h0,
    mon_on:   1'h0
  };

endpackage : tpm_pkg

// ---- rtl/tpm_monitor.sv ----
// throttle pin monitor: status/control and single-assertion counter
module tpm_monitor #(
  parameter int TICK_CYC = tpm_pkg::TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hot_throttle_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  tpm_pkg::tpm_state_t st_q;
  tpm_pkg::tpm_state_t st_d;

  logic req;
  logic accept;
  logic wr_go;
  logic tick;
  logic run;
  logic eff_pin;
  logic viol;
  logic wr_status;
  logic srst;

  function automatic logic hit(input logic [4:0] a,
                               input logic [4:0] off);
    hit = (a[4:2] == off[4:2]);
  endfunction : hit

  assign req       = avs_read | avs_write;
  assign accept    = req & ~st_q.ack & ce;
  assign wr_go     = avs_write & st_q.ack & ce;
  assign wr_status = wr_go & hit(avs_address, tpm_pkg::OFF_STATUS);
  // self-clearing: the bit is never stored, so it always reads zero
  assign srst      = wr_status & avs_byteenable[0]
                   & avs_writedata[tpm_pkg::BIT_SRST];
  // free-running divider, not gated by the monitor enable
  assign tick      = (st_q.tick_cnt == 16'(TICK_CYC - 1));
  assign run       = ce & st_q.mon_on;
  assign eff_pin   = st_q.filt_on ? st_q.filt : hot_throttle_n;
  assign viol      = (st_q.limit != 16'h0000)
                   & (st_q.acnt >= st_q.limit);

  // one wait state: read data is registered at the accept edge
  assign avs_waitrequest = req & ~(st_q.ack & ce);
  assign avs_readdata    = st_q.rdata;
  // level request from flag and enable flops
  assign irq = (st_q.pflag & st_q.pie)
             | (st_q.aflag & st_q.aie);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] rd_word(input tpm_pkg::tpm_state_t s,
                                          input logic [4:0] a,
                                          input logic [3:0] be);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(a, tpm_pkg::OFF_PERIOD))
      w = {8'h00, s.period};
    else if (hit(a, tpm_pkg::OFF_STATUS))
    begin
      w[tpm_pkg::BIT_PFLAG]    = s.pflag;
      w[tpm_pkg::BIT_AFLAG]    = s.aflag;
      w[tpm_pkg::BIT_FILT_ON]  = s.filt_on;
      w[tpm_pkg::BIT_PIE]      = s.pie;
      w[tpm_pkg::BIT_AIE]      = s.aie;
      w[tpm_pkg::BIT_PIN_VIEW] = s.pin_view;
      w[tpm_pkg::BIT_MON_ON]   = s.mon_on;
    end
    else if (hit(a, tpm_pkg::OFF_COUNT))
    begin
      // narrow reads that skip byte zero see the held upper byte
      if (!be[0] && be != 4'hF)
        w = {16'h0000, s.hold, s.acnt[7:0]};
      else
        w = {16'h0000, s.acnt};
    end
    else if (hit(a, tpm_pkg::OFF_LIMIT))
      w = {16'h0000, s.limit};
    rd_word = w;
  endfunction : rd_word

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      st_d.ack = req & ~st_q.ack;
      st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

      if (accept && avs_read)
      begin
        st_d.rdata = rd_word(st_q, avs_address, avs_byteenable);
        if (hit(avs_address, tpm_pkg::OFF_COUNT) && avs_byteenable[0])
          st_d.hold = st_q.acnt[15:8];
      end

      if (run)
      begin
        st_d.pin_view = hot_throttle_n;
        if (tick)
        begin
          st_d.samp = {st_q.samp[1:0], hot_throttle_n};
          // change only after three equal samples in a row
          if (st_d.samp == {3{st_d.samp[0]}})
            st_d.filt = st_d.samp[0];
          if (eff_pin)
            st_d.acnt = 16'h0000;
          else if (st_q.acnt != tpm_pkg::CNT_MAX)
            st_d.acnt = st_q.acnt + 16'h0001;
          if (st_q.period != 24'h00_0000)
          begin
            if (st_q.pcnt <= 24'h00_0001)
              st_d.pcnt = st_q.period;
            else
              st_d.pcnt = st_q.pcnt - 24'h00_0001;
          end
        end
      end

      // software clears first, so a hardware set below wins
      if (wr_status && avs_byteenable[1])
      begin
        if (avs_writedata[tpm_pkg::BIT_PFLAG])
          st_d.pflag = 1'b0;
        if (avs_writedata[tpm_pkg::BIT_AFLAG] && !viol)
          st_d.aflag = 1'b0;
      end
      if (run && tick && st_q.period != 24'h00_0000
          && st_q.pcnt == 24'h00_0001)
        st_d.pflag = 1'b1;
      if (run && viol)
        st_d.aflag = 1'b1;

      if (wr_status && avs_byteenable[0])
      begin
        st_d.filt_on = avs_writedata[tpm_pkg::BIT_FILT_ON];
        st_d.pie     = avs_writedata[tpm_pkg::BIT_PIE];
        st_d.aie     = avs_writedata[tpm_pkg::BIT_AIE];
        st_d.mon_on  = avs_writedata[tpm_pkg::BIT_MON_ON];
      end
      if (wr_go && hit(avs_address, tpm_pkg::OFF_PERIOD))
      begin
        if (avs_byteenable[0])
          st_d.period[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
          st_d.period[15:8] = avs_writedata[15:8];
        if (avs_byteenable[2])
          st_d.period[23:16] = avs_writedata[23:16];
        st_d.pcnt = 24'h00_0000;
      end
      if (wr_go && hit(avs_address, tpm_pkg::OFF_LIMIT))
      begin
        if (avs_byteenable[0])
          st_d.limit[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
          st_d.limit[15:8] = avs_writedata[15:8];
      end

      if (srst)
      begin
        // read data and divider survive the monitor reset; ack is cleared
        st_d          = tpm_pkg::RESET_ST;
        st_d.ack      = st_q.ack & 1'b0;
        st_d.rdata    = st_q.rdata;
        st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= tpm_pkg::RESET_ST;
    else
      st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_req_taken;
    req && !st_q.ack && ce;
  endsequence

  sequence s_answer;
    ce && !avs_waitrequest;
  endsequence

  sequence s_run_tick;
    run && tick && !srst;
  endsequence

  bus_answer_a: assert property (s_req_taken ##1 ce |-> s_answer)
    else $error("bus request not answered after one wait cycle");

  period_set_a: assert property (
    s_run_tick ##0 (st_q.period != 24'h00_0000
                    && st_q.pcnt == 24'h00_0001) |=> st_q.pflag)
    else $error("period flag missed at counter expiry");

  limit_set_a: assert property (
    run && viol && !srst |=> st_q.aflag)
    else $error("limit flag not set on violation");

  limit_hold_a: assert property (
    st_q.aflag && viol && !srst |=> st_q.aflag)
    else $error("limit flag cleared during violation");

  filter_edge_a: assert property (
    $changed(st_q.filt) && $past(st_q.filt_on) && $past(srst) == 1'b0
    |-> st_q.samp == {3{st_q.filt}})
    else $error("filtered pin changed without three equal samples");

  soft_reset_a: assert property (
    srst |=> st_q.acnt == 16'h0000 && !st_q.mon_on && !st_q.pflag
             && !st_q.aflag && st_q.limit == 16'h0000)
    else $error("soft reset left monitor state behind");

  irq_block_a: assert property (
    !st_q.pie && !st_q.aflag |-> !irq)
    else $error("period interrupt while blocked");

  irq_assert_a: assert property (
    $rose(st_q.aflag) && st_q.aie |-> irq)
    else $error("limit interrupt missing while enabled");

  pin_view_a: assert property (
    run && !srst |=> st_q.pin_view == $past(hot_throttle_n))
    else $error("pin view did not follow pin");

  frozen_off_a: assert property (
    !st_q.mon_on && !wr_go |=> $stable(st_q.acnt) && $stable(st_q.pcnt)
                               && $stable(st_q.pin_view))
    else $error("monitor state moved while disabled");

  hold_latch_a: assert property (
    accept && avs_read && avs_byteenable[0]
    && hit(avs_address, tpm_pkg::OFF_COUNT)
    |=> st_q.hold == $past(st_q.acnt[15:8]))
    else $error("count upper byte not held on byte zero read");

  count_clear_a: assert property (
    s_run_tick ##0 eff_pin |=> st_q.acnt == 16'h0000)
    else $error("count not cleared with pin high");

  count_sat_a: assert property (
    s_run_tick ##0 (!eff_pin && st_q.acnt == tpm_pkg::CNT_MAX)
    |=> st_q.acnt == tpm_pkg::CNT_MAX)
    else $error("count wrapped past all ones");

  zero_limit_a: assert property (
    st_q.limit == 16'h0000 && !st_q.aflag |=> !st_q.aflag)
    else $error("limit flag set with comparison disabled");

  period_load_a: assert property (
    s_run_tick ##0 (st_q.period != 24'h00_0000
                    && st_q.pcnt <= 24'h00_0001) && !wr_go
    |=> st_q.pcnt == $past(st_q.period))
    else $error("period counter not reloaded");

  tick_space_a: assert property (
    ce && tick |=> !tick)
    else $error("tick lasted more than one cycle");

  // finer steps; saturation and long periods need far longer runs
  period_irq_a: assert property (
    $rose(st_q.pflag) && st_q.pie |-> irq)
    else $error("period interrupt missing while enabled");

  limit_irq_off_a: assert property (
    !st_q.aie && !st_q.pflag |-> !irq)
    else $error("limit interrupt while blocked");

  period_clear_a: assert property (
    wr_status && avs_byteenable[1] && avs_writedata[tpm_pkg::BIT_PFLAG]
    && !(run && tick) |=> !st_q.pflag)
    else $error("period flag not cleared by write of one");

  period_keep_a: assert property (
    st_q.pflag && !wr_status |=> st_q.pflag)
    else $error("period flag dropped without a clear");

  limit_clear_a: assert property (
    wr_status && avs_byteenable[1] && avs_writedata[tpm_pkg::BIT_AFLAG]
    && !viol |=> !st_q.aflag)
    else $error("limit flag not cleared once violation ended");

  count_step_a: assert property (
    s_run_tick ##0 (!eff_pin && st_q.acnt != tpm_pkg::CNT_MAX)
    |=> st_q.acnt == $past(st_q.acnt) + 16'h0001)
    else $error("count did not step on a low tick");

  count_idle_a: assert property (
    !tick && !srst |=> $stable(st_q.acnt))
    else $error("count moved between ticks");

  period_step_a: assert property (
    s_run_tick ##0 (st_q.period != 24'h00_0000
                    && st_q.pcnt > 24'h00_0001 && !wr_go)
    |=> st_q.pcnt == $past(st_q.pcnt) - 24'h00_0001)
    else $error("period counter did not count down");

  reserved_zero_a: assert property (
    accept && avs_read && hit(avs_address, tpm_pkg::OFF_STATUS)
    |=> st_q.rdata[31:12] == 20'h0_0000 && st_q.rdata[9:6] == 4'h0
        && st_q.rdata[tpm_pkg::BIT_SRST] == 1'b0)
    else $error("reserved status bits read non-zero");

  ce_freeze_a: assert property (
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

endmodule : tpm_monitor

// ---- tb/tpm_cpu_pin.sv ----
// processor-side model that drives the throttle pin
module tpm_cpu_pin (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hold_low,
  input  wire logic        pulse_go,
  input  wire logic [15:0] pulse_len,
  output logic             hot_throttle_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_q;
  // pin is a driven level, never released, so it has no float state
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      left_q <= 16'h0000;
    else if (pulse_go)
      left_q <= pulse_len;
    else if (left_q != 16'h0000)
      left_q <= left_q - 16'h0001;
  assign hot_throttle_n = !(hold_low || left_q != 16'h0000);
endmodule : tpm_cpu_pin

// ---- tb/test_throttle_pin_monitor_ctrl.sv ----
// self-checking bench for the throttle pin monitor
module test_throttle_pin_monitor_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // short tick keeps the run brief; the ticks() and pulse() waits scale with it
  localparam int TC = 8;
  logic        clk_sys, rst_n, ce, hold_low, pulse_go, hot_throttle_n;
  logic [15:0] pulse_len;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, irq;
  logic [31:0] avs_writedata, avs_readdata, rd, c1;
  logic [3:0]  avs_byteenable;
  int          err_count, comparisons, cyc, k, seed;

  tpm_monitor #(.TICK_CYC(TC)) tpm_monitor_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .hot_throttle_n(hot_throttle_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  tpm_cpu_pin tpm_cpu_pin_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .hold_low(hold_low), .pulse_go(pulse_go), .pulse_len(pulse_len),
    .hot_throttle_n(hot_throttle_n));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic cmp(input string w, input logic [31:0] e, q);
    comparisons++;
    if (q !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", w, e, q);
    end
  endtask : cmp

  task automatic cmp_rng(input string w, input int lo, hi,
                         input logic [31:0] q);
    comparisons++;
    if ($isunknown(q) || q < lo || q > hi)
    begin
      err_count++;
      $display("unexpected %s exp %0d..%0d got %h", w, lo, hi, q);
    end
  endtask : cmp_rng

  // request held until waitrequest is seen low, taken at that edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    // only the bench timeout ends a wait that never answers
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF, rd);
  endtask : wr

  task automatic chk(input string w, input logic [4:0] a,
                     input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, 4'hF, v);
    cmp(w, e, v);
  endtask : chk

  task automatic chk_irq(input logic e);
    @(negedge clk_sys);
    cmp("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk_sys);
  endtask : chk_irq

  // f is {period flag, limit flag, period ie, limit ie, pin, on}
  function automatic logic [31:0] stat(input logic [5:0] f);
    stat = 32'h0000_0000;
    stat[tpm_pkg::BIT_PFLAG]    = f[5];
    stat[tpm_pkg::BIT_AFLAG]    = f[4];
    stat[tpm_pkg::BIT_PIE]      = f[3];
    stat[tpm_pkg::BIT_AIE]      = f[2];
    stat[tpm_pkg::BIT_PIN_VIEW] = f[1];
    stat[tpm_pkg::BIT_MON_ON]   = f[0];
  endfunction : stat

  task automatic ticks(input int n);
    repeat (n * TC) @(posedge clk_sys);
  endtask : ticks

  task automatic pulse(input int n);
    pulse_len <= 16'(n * TC);
    pulse_go  <= 1'b1;
    @(posedge clk_sys);
    pulse_go <= 1'b0;
  endtask : pulse

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    {rst_n, hold_low, pulse_go, avs_read, avs_write} = 5'h00;
    {pulse_len, avs_address, avs_writedata} = 53'h0;
    avs_byteenable = 4'hF;
    ce = 1'b1;
    seed = 32'h8FB0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++)
      chk("reset value", 5'(i * 4 + 8), 32'h0);
    $display("test reset values done");
    wr(tpm_pkg::OFF_LIMIT, 32'h3);
    wr(tpm_pkg::OFF_STATUS, 32'h1);
    hold_low <= 1'b1;
    ticks(6);
    chk("limit flag", tpm_pkg::OFF_STATUS, 32'h401);
    chk_irq(1'b0);
    wr(tpm_pkg::OFF_STATUS, 32'h405);
    chk("clear in violation", tpm_pkg::OFF_STATUS, 32'h405);
    chk_irq(1'b1);
    hold_low <= 1'b0;
    ticks(2);
    wr(tpm_pkg::OFF_STATUS, 32'h405);
    chk("limit cleared", tpm_pkg::OFF_STATUS, 32'h7);
    $display("test limit flag done");
    wr(tpm_pkg::OFF_STATUS, 32'h9);
    wr(tpm_pkg::OFF_PERIOD, 32'h3);
    ticks(6);
    chk("period flag", tpm_pkg::OFF_STATUS, 32'h80B);
    chk_irq(1'b1);
    wr(tpm_pkg::OFF_PERIOD, 32'h0);
    wr(tpm_pkg::OFF_STATUS, 32'h1);
    chk("zero write", tpm_pkg::OFF_STATUS, 32'h803);
    chk_irq(1'b0);
    wr(tpm_pkg::OFF_STATUS, 32'h801);
    chk("period cleared", tpm_pkg::OFF_STATUS, 32'h3);
    $display("test period flag done");
    wr(tpm_pkg::OFF_LIMIT, 32'h1);
    wr(tpm_pkg::OFF_STATUS, 32'h21);
    pulse(2);
    ticks(8);
    chk("filtered pulse", tpm_pkg::OFF_STATUS, 32'h23);
    wr(tpm_pkg::OFF_STATUS, 32'h1);
    pulse(2);
    ticks(4);
    chk("raw pulse", tpm_pkg::OFF_STATUS, 32'h403);
    wr(tpm_pkg::OFF_STATUS, 32'h401);
    wr(tpm_pkg::OFF_LIMIT, 32'h0);
    $display("test filter done");
    repeat (4)
    begin
      k = 4 + ($random(seed) & 15);
      hold_low <= 1'b1;
      ticks(k);
      bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'hF, rd);
      cmp_rng("count", k - 1, k + 1, rd);
      chk("zero limit", tpm_pkg::OFF_STATUS, stat(6'h01));
      hold_low <= 1'b0;
      ticks(2);
      chk("count cleared", tpm_pkg::OFF_COUNT, 32'h0);
    end
    $display("test random counts done");
    hold_low <= 1'b1;
    ticks(300);
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'h1, c1);
    ticks(300);
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'h2, rd);
    cmp("held byte", {24'h0, c1[15:8]}, {24'h0, rd[15:8]});
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'hF, rd);
    cmp_rng("live count", 599, 602, rd);
    $display("test byte latch done");
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'hF, c1);
    ce <= 1'b0;
    ticks(5);
    ce <= 1'b1;
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'hF, rd);
    cmp_rng("count with clock held", int'(c1), int'(c1) + 1, rd);
    $display("test clock enable done");
    wr(tpm_pkg::OFF_STATUS, 32'h0);
    bus(1'b0, tpm_pkg::OFF_COUNT, 32'h0, 4'hF, c1);
    hold_low <= 1'b0;
    ticks(5);
    chk("frozen count", tpm_pkg::OFF_COUNT, c1);
    chk("frozen pin view", tpm_pkg::OFF_STATUS, stat(6'h00));
    $display("test disable done");
    wr(tpm_pkg::OFF_LIMIT, 32'h1234);
    wr(tpm_pkg::OFF_PERIOD, 32'h7);
    wr(tpm_pkg::OFF_STATUS, 32'h39);
    chk("soft reset status", tpm_pkg::OFF_STATUS, 32'h0);
    chk("soft reset limit", tpm_pkg::OFF_LIMIT, 32'h0);
    chk("soft reset period", tpm_pkg::OFF_PERIOD, 32'h0);
    chk("soft reset count", tpm_pkg::OFF_COUNT, 32'h0);
    $display("test soft reset done");
    wr(tpm_pkg::OFF_LIMIT, 32'h0000_00AB);
    chk("limit write", tpm_pkg::OFF_LIMIT, 32'h0000_00AB);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("hard reset limit", tpm_pkg::OFF_LIMIT, 32'h0);
    $display("test hard reset done");
    results();
  end
endmodule : test_throttle_pin_monitor_ctrl
